// >>> design/srl_latch.sv
// Set-reset latch block with software pulses, source enables and pins.
// Assumes comparator outputs and the input pin are asynchronous to CLK.
//
// Added by the designer: the plain strobed port and the address map.
`include "srl_cfg.svh"
`default_nettype none
module srl_latch
    import srl_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [`SRL_ADDR_W-1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic CMP_A_OUT,
    input wire logic CMP_B_OUT,
    input wire logic LATCH_INPUT_PIN,
    output logic LATCH_TRUE_OUT_PIN,
    output logic LATCH_TRUE_OUT_OE,
    output logic LATCH_INVERTED_OUT_PIN,
    output logic LATCH_INVERTED_OUT_OE,
    output logic LATCH_Q
);
    logic latch_enable_r;
    srl_div_t pulse_divider_select_r;
    logic true_output_pin_enable_r;
    logic inverted_output_pin_enable_r;
    srl_src_s src_r;
    logic [1:0] set_cnt_r;
    logic [1:0] rst_cnt_r;
    logic [`SRL_EXT_N-1:0] ext_in;
    logic [`SRL_EXT_N-1:0] ext_meta_r;
    logic [`SRL_EXT_N-1:0] ext_sync_r;
    logic cmp_a_sync;
    logic cmp_b_sync;
    logic pin_sync;
    logic divided_pulse_train;
    logic set_in;
    logic reset_in;
    logic q_r;
    logic q_nxt;
    logic wr_ctrl;
    logic wr_src;
    localparam logic [7:0] ctrl_rst = `SRL_RST_CONTROL;

    // Register select, shared by the write and read decoders
    function automatic logic reg_hit(input logic [`SRL_ADDR_W-1:0] a,
            input logic [`SRL_ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    assign wr_ctrl = WR && reg_hit(ADDR, `SRL_OFS_CONTROL);
    assign wr_src = WR && reg_hit(ADDR, `SRL_OFS_SOURCES);

    srl_pulser u_pulser (
        .clk(CLK),
        .rst(SYS_RST),
        .div_sel(pulse_divider_select_r),
        .pulse_r(divided_pulse_train)
    );

    // Control register
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            {latch_enable_r, pulse_divider_select_r,
             true_output_pin_enable_r, inverted_output_pin_enable_r} <=
                ctrl_rst[`SRL_BIT_LEN:`SRL_BIT_NQEN];
        end else if (wr_ctrl) begin
            latch_enable_r <= WDATA[`SRL_BIT_LEN];
            pulse_divider_select_r <=
                WDATA[`SRL_BIT_DIV_HI:`SRL_BIT_DIV_LO];
            true_output_pin_enable_r <= WDATA[`SRL_BIT_QEN];
            inverted_output_pin_enable_r <= WDATA[`SRL_BIT_NQEN];
        end
    end

    // Source enable register
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            src_r <= `SRL_RST_SOURCES;
        end else if (wr_src) begin
            src_r <= WDATA;
        end
    end

    // Software set pulse: two clocks from the write; writing zero is ignored
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            set_cnt_r <= 2'h0;
        end else if (wr_ctrl && WDATA[`SRL_BIT_PS]) begin
            set_cnt_r <= `SRL_PULSE_CYC;
        end else if (set_cnt_r != 2'h0) begin
            set_cnt_r <= set_cnt_r - `SRL_PULSE_LAST;
        end
    end

    // Software reset pulse
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rst_cnt_r <= 2'h0;
        end else if (wr_ctrl && WDATA[`SRL_BIT_PR]) begin
            rst_cnt_r <= `SRL_PULSE_CYC;
        end else if (rst_cnt_r != 2'h0) begin
            rst_cnt_r <= rst_cnt_r - `SRL_PULSE_LAST;
        end
    end

    // Two-stage synchronisers for external inputs
    assign ext_in = {LATCH_INPUT_PIN, CMP_B_OUT, CMP_A_OUT};
    for (genvar gi = 0; gi < `SRL_EXT_N; gi++) begin : g_sync
        always_ff @(posedge CLK) begin
            ext_meta_r[gi] <= ext_in[gi];
            ext_sync_r[gi] <= ext_meta_r[gi];
        end
    end
    assign cmp_a_sync = ext_sync_r[`SRL_EXT_CMP_A];
    assign cmp_b_sync = ext_sync_r[`SRL_EXT_CMP_B];
    assign pin_sync = ext_sync_r[`SRL_EXT_PIN];

    // Active-high OR of enabled sources
    always_comb begin
        set_in = (set_cnt_r != 2'h0)
            || (src_r.pin_set_enable && pin_sync)
            || (src_r.clock_set_enable && divided_pulse_train)
            || (src_r.cmp_b_set_enable && cmp_b_sync)
            || (src_r.cmp_a_set_enable && cmp_a_sync);
        reset_in = (rst_cnt_r != 2'h0)
            || (src_r.pin_reset_enable && pin_sync)
            || (src_r.clock_reset_enable && divided_pulse_train)
            || (src_r.cmp_b_reset_enable && cmp_b_sync)
            || (src_r.cmp_a_reset_enable && cmp_a_sync);
        if (reset_in) begin
            q_nxt = 1'b0;
        end else if (set_in) begin
            q_nxt = 1'b1;
        end else begin
            q_nxt = q_r;
        end
    end

    // Latch state is not touched by SYS_RST; it follows its inputs only while latch_enable_r is set
    always_ff @(posedge CLK) begin
        if (latch_enable_r) begin
            q_r <= q_nxt;
        end
    end

    // Pin drivers
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            LATCH_TRUE_OUT_OE <= 1'b0;
            LATCH_INVERTED_OUT_OE <= 1'b0;
        end else begin
            LATCH_TRUE_OUT_OE <= true_output_pin_enable_r;
            LATCH_INVERTED_OUT_OE <= inverted_output_pin_enable_r;
        end
    end

    always_ff @(posedge CLK) begin
        LATCH_Q <= q_r;
        LATCH_TRUE_OUT_PIN <= q_r;
        LATCH_INVERTED_OUT_PIN <= ~q_r;
    end

    // Read port; pulse bits always read zero
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            RDATA <= 8'h00;
        end else if (RD && reg_hit(ADDR, `SRL_OFS_CONTROL)) begin
            RDATA <= {latch_enable_r, pulse_divider_select_r,
                      true_output_pin_enable_r,
                      inverted_output_pin_enable_r, 2'h0}
                     & `SRL_CTRL_RD_MASK;
        end else if (RD && reg_hit(ADDR, `SRL_OFS_SOURCES)) begin
            RDATA <= src_r;
        end else begin
            RDATA <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// >>> design/srl_cfg.svh
// Constants for the set-reset latch block: register offsets, fields, timing.
// Assumes a 20 MHz CLK and an 8-bit register port.
`ifndef SRL_CFG_SVH
`define SRL_CFG_SVH

`define SRL_ADDR_W 4
`define SRL_OFS_CONTROL 4'h0
`define SRL_OFS_SOURCES 4'h1
`define SRL_BIT_LEN 7
`define SRL_BIT_DIV_HI 6
`define SRL_BIT_DIV_LO 4
`define SRL_BIT_QEN 3
`define SRL_BIT_NQEN 2
`define SRL_BIT_PS 1
`define SRL_BIT_PR 0
`define SRL_RST_CONTROL 8'h00
`define SRL_RST_SOURCES 8'h00
`define SRL_CTRL_RD_MASK 8'hFC
`define SRL_DIV_MIN_LOG2 2
`define SRL_DIV_W 9
`define SRL_PULSE_CYC 2'h2
`define SRL_PULSE_LAST 2'h1
`define SRL_EXT_CMP_A 0
`define SRL_EXT_CMP_B 1
`define SRL_EXT_PIN 2
`define SRL_EXT_N 3

`endif

// >>> design/srl_pkg.sv
// Types of the set-reset latch block.
// Assumes srl_cfg.svh is on the include path.
`default_nettype none
package srl_pkg;
    typedef struct packed {
        logic pin_set_enable;
        logic clock_set_enable;
        logic cmp_b_set_enable;
        logic cmp_a_set_enable;
        logic pin_reset_enable;
        logic clock_reset_enable;
        logic cmp_b_reset_enable;
        logic cmp_a_reset_enable;
    } srl_src_s;
    typedef logic [2:0] srl_div_t;
endpackage
`default_nettype wire

// >>> design/srl_pulser.sv
// Divided pulse generator: a two-clock pulse once per selected period.
// Assumes CLK is the peripheral clock and SYS_RST is synchronous.
`include "srl_cfg.svh"
`default_nettype none
module srl_pulser
    import srl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire srl_div_t div_sel,
    output logic pulse_r
);
    logic [`SRL_DIV_W-1:0] cnt_r;
    logic [`SRL_DIV_W-1:0] last;

    // Period is 2^(code+2) cycles, count wraps at period-1
    assign last = `SRL_DIV_W'((1 << (div_sel + `SRL_DIV_MIN_LOG2)) - 1);

    always_ff @(posedge clk) begin
        if (rst || cnt_r >= last) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + `SRL_DIV_W'(1);
        end
    end

    // High in the first two cycles of each period
    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_r <= 1'b0;
        end else begin
            pulse_r <= (cnt_r >= last) || (cnt_r == '0);
        end
    end
endmodule
`default_nettype wire

// >>> test/srl_checker.sv
// Port assertions for the set-reset latch block.
// Assumes a bind onto srl_latch; one clock, synchronous reset.
`include "srl_cfg.svh"
`default_nettype none
module srl_checker (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [`SRL_ADDR_W-1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic LATCH_TRUE_OUT_PIN,
    input wire logic LATCH_TRUE_OUT_OE,
    input wire logic LATCH_INVERTED_OUT_PIN,
    input wire logic LATCH_INVERTED_OUT_OE,
    input wire logic LATCH_Q
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    wire logic cw = WR && ADDR == `SRL_OFS_CONTROL;
    a_true_oe: assert property (cw |-> ##2
        LATCH_TRUE_OUT_OE == $past(WDATA[`SRL_BIT_QEN], 2))
        else $error("true enable");
    a_inv_oe: assert property (cw |-> ##2
        LATCH_INVERTED_OUT_OE == $past(WDATA[`SRL_BIT_NQEN], 2))
        else $error("inverted enable");
    a_pins_q: assert property ($stable(LATCH_Q) |->
        LATCH_TRUE_OUT_PIN == LATCH_Q && LATCH_INVERTED_OUT_PIN != LATCH_Q)
        else $error("pins off latch");
    a_sw_set: assert property (
        cw && WDATA[7] && WDATA[1:0] == 2'h2 |-> ##[1:4] LATCH_Q)
        else $error("set pulse");
    a_sw_reset: assert property (
        cw && WDATA[7] && WDATA[0] |-> ##[1:4] !LATCH_Q)
        else $error("reset pulse");
    a_pulse_rd: assert property (
        $past(RD) && $past(ADDR) == `SRL_OFS_CONTROL |-> RDATA[1:0] == 2'h0)
        else $error("pulse bits read");
    a_rd_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("idle read data");
    a_rst_oe: assert property ($past(SYS_RST) |->
        !LATCH_TRUE_OUT_OE && !LATCH_INVERTED_OUT_OE) else $error("reset oe");
    c_set: cover property (cw && WDATA[1]);
    c_rise: cover property ($rose(LATCH_Q));
    c_fall: cover property ($fell(LATCH_Q));
endmodule
`default_nettype wire

// >>> test/srl_far.sv
// Far side: two comparator outputs and the latch input pin.
// Assumes the bench commands the levels; they move at CLK edges.
`default_nettype none
module srl_far (
    input wire logic clk,
    input wire logic [2:0] lvl,
    output logic cmp_a,
    output logic cmp_b,
    output logic pin
);
    always_ff @(posedge clk) begin
        {pin, cmp_b, cmp_a} <= lvl;
    end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Bench for the set-reset latch block.
// Assumes the design and checker compile first.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK, SYS_RST, WR, RD, ca, cb, pin, to, toe, io, ioe, q;
    logic [3:0] ADDR;
    logic [7:0] WDATA, RDATA;
    logic [2:0] lvl;
    int n_errors = 0, num_checks = 0, n, cyc = 0, t0;
    srl_latch DUT (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .CMP_A_OUT(ca), .CMP_B_OUT(cb),
        .LATCH_INPUT_PIN(pin), .LATCH_TRUE_OUT_PIN(to),
        .LATCH_TRUE_OUT_OE(toe), .LATCH_INVERTED_OUT_PIN(io),
        .LATCH_INVERTED_OUT_OE(ioe), .LATCH_Q(q));
    srl_far far_u (.clk(CLK), .lvl(lvl), .cmp_a(ca), .cmp_b(cb), .pin(pin));
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    always @(posedge CLK) cyc <= cyc + 1;
    task chk(input string s, input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        @(negedge CLK);
        chk("rdata", 16'(RDATA), 16'(e));
    endtask
    // Waits for the latch level, bounded; a miss ends the run
    task wq(input logic e);
        n = 0;
        do begin
            @(negedge CLK);
            n++;
        end while (q !== e && n < 600);
        chk("latch", 16'(q), 16'(e));
        if (q !== e) test_done;
    endtask
    initial begin
        SYS_RST = 1'b1;
        {WR, RD, ADDR, WDATA, lvl} = '0;
        repeat (12) @(posedge CLK);
        SYS_RST <= 1'b0;
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h00);
        wr(4'h1, 8'hA5);
        rd(4'h1, 8'hA5);
        rd(4'h2, 8'h00);
        wr(4'h1, 8'h00);
        $display("register test done");
        wr(4'h0, 8'h81);
        wq(1'b0);
        wr(4'h0, 8'hFF);
        rd(4'h0, 8'hFC);
        wq(1'b0);
        chk("pins", 16'({toe, to, ioe, io}), 16'hB);
        wr(4'h0, 8'h02);
        repeat (8) @(negedge CLK);
        chk("off", 16'(q), 16'h0);
        wr(4'h0, 8'h8E);
        wq(1'b1);
        chk("pins", 16'({toe, to, ioe, io}), 16'hE);
        $display("output test done");
        // Reset in mid-run: registers and pin enables clear again
        @(posedge CLK);
        SYS_RST <= 1'b1;
        repeat (3) @(posedge CLK);
        SYS_RST <= 1'b0;
        rd(4'h0, 8'h00);
        chk("oe", 16'({toe, ioe}), 16'h0);
        $display("reset test done");
        for (int k = 0; k < 8; k++) begin
            wr(4'h1, 8'h00);
            wr(4'h0, k > 3 ? 8'h81 : 8'h82);
            wq(k < 4);
            lvl <= 3'h7;
            repeat (12) @(negedge CLK);
            chk("held", 16'(q), 16'(k < 4));
            // Only the level of the source under test stays high from here on; none for the pulse train (k % 4 == 2)
            case (k % 4)
                0: lvl <= 3'h1;
                1: lvl <= 3'h2;
                2: lvl <= 3'h0;
                default: lvl <= 3'h4;
            endcase
            repeat (4) @(negedge CLK);
            wr(4'h1, 8'h01 << k);
            wq(k > 3);
            lvl <= 3'h0;
        end
        $display("source test done");
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h00);
        for (int c = 1; c < 8; c++) begin
            wr(4'h0, 8'(c << 4));
            wr(4'h0, 8'(8'h81 | c << 4));
            wq(1'b0);
            wr(4'h1, 8'h40);
            wq(1'b1);
            t0 = cyc;
            wr(4'h0, 8'(8'h81 | c << 4));
            wq(1'b0);
            wq(1'b1);
            chk("period", 16'(cyc - t0), 16'(4 << c));
            wr(4'h0, 8'(c << 4));
            wr(4'h1, 8'h00);
        end
        $display("divider test done");
        // Comparator A holds set high, the pulse train resets: q dips
        wr(4'h0, 8'h00);
        lvl <= 3'h1;
        wr(4'h1, 8'h14);
        wr(4'h0, 8'h80);
        wq(1'b0);
        wq(1'b1);
        wq(1'b0);
        wq(1'b1);
        chk("pulse width", 16'(n), 16'h2);
        wq(1'b0);
        chk("pulse gap", 16'(n), 16'h2);
        lvl <= 3'h0;
        $display("pulse test done");
        test_done;
    end
endmodule
bind srl_latch srl_checker chk_u (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LATCH_Q(LATCH_Q),
    .LATCH_TRUE_OUT_PIN(LATCH_TRUE_OUT_PIN),
    .LATCH_TRUE_OUT_OE(LATCH_TRUE_OUT_OE),
    .LATCH_INVERTED_OUT_PIN(LATCH_INVERTED_OUT_PIN),
    .LATCH_INVERTED_OUT_OE(LATCH_INVERTED_OUT_OE));
`default_nettype wire
